// ### verilog/frp_pkg.sv
package frp_pkg;
  localparam logic [7:0] LVL0_BYTE = 8'hAA;
  localparam logic [7:0] LVL0_COMP = 8'h55;
  localparam logic [7:0] LVL2_BYTE = 8'hCC;
  localparam logic [7:0] LVL2_COMP = 8'h33;
  localparam int         WP_BITS   = 8;
  localparam int         PAGE_BITS = 6;
  localparam int         GROUP_SH  = 1;
  localparam int         KEY_STEPS = 2;

  typedef enum logic [1:0] {
    FRP_LVL0,
    FRP_LVL1,
    FRP_LVL2
  } frp_level_t;

  typedef enum logic [2:0] {
    FRP_OP_NONE,
    FRP_OP_PROG,
    FRP_OP_PAGE_ERASE,
    FRP_OP_MASS_ERASE,
    FRP_OP_OPT_PROG,
    FRP_OP_OPT_ERASE
  } frp_op_t;

  typedef enum logic [1:0] {
    FRP_AREA_MAIN,
    FRP_AREA_SYSMEM,
    FRP_AREA_OPTION,
    FRP_AREA_BACKUP
  } frp_area_t;

  typedef enum logic [1:0] {
    FRP_SIZE_BYTE,
    FRP_SIZE_HALF,
    FRP_SIZE_WORD
  } frp_size_t;
endpackage

// ### verilog/frp_if.sv
`timescale 1ns/1ps
interface frp_if;
  logic                  req;
  logic                  is_write;
  frp_pkg::frp_area_t    area;
  frp_pkg::frp_size_t    size;
  logic                  is_reg;
  frp_pkg::frp_op_t      op;
  logic [frp_pkg::PAGE_BITS-1:0] page;
  logic                  level_byte_sel;
  logic [7:0]            wdata;
  logic                  debug_mode;
  logic                  boot_ram;
  logic                  boot_loader;
  logic                  done;
  logic                  granted;
  logic                  bus_error;

  modport dev (input req, is_write, area, size, is_reg, op, page, level_byte_sel, wdata,
               debug_mode, boot_ram, boot_loader, output done, granted, bus_error);
  modport host (output req, is_write, area, size, is_reg, op, page, level_byte_sel, wdata,
                debug_mode, boot_ram, boot_loader, input done, granted, bus_error);
endinterface

// ### verilog/frp_device.sv
`timescale 1ns/1ps
module frp_device (
  input  wire logic                          clk,           // system clock
  input  wire logic                          resetn,        // async reset
  frp_if.dev                                 bus,           // access side
  input  wire logic [7:0]                    opt_level_byte,  // stored level byte
  input  wire logic [7:0]                    opt_level_comp,  // stored complement
  input  wire logic [frp_pkg::WP_BITS-1:0]   opt_protect_bits, // group bits, 1=free
  input  wire logic                          option_reload_trigger, // reload pulse
  input  wire logic                          key_good,      // correct key pair seen
  input  wire logic                          clear_wre,     // software clears enable
  input  wire logic                          clr_op_end,    // w1c end of operation
  input  wire logic                          clr_wrperr,    // w1c protect error
  input  wire logic                          clr_prog_err,  // w1c program error
  input  wire logic                          end_of_operation_irq_enable, // eop irq enable
  input  wire logic                          error_irq_enable, // error irq enable
  output logic [1:0]                         level,         // latched level
  output logic                               option_write_enable, // option write open
  output logic                               end_of_operation_flag, // eop flag
  output logic                               write_protect_error_flag, // wrp error
  output logic                               program_error_flag, // program error
  output logic                               irq,           // interrupt request
  output logic                               debug_disable, // level 2 debug lock
  output logic                               boot_disable,  // level 2 boot lock
  output logic                               mass_erase_pulse, // main array erase
  output logic                               backup_clear_pulse // backup reset
);
  frp_pkg::frp_level_t lvl, next_lvl;
  logic [frp_pkg::WP_BITS-1:0] wp_mask, next_wp_mask;
  logic [frp_pkg::PAGE_BITS-frp_pkg::GROUP_SH-1:0] grp;
  logic loaded, next_loaded, dis_q, next_dis;
  logic wre, next_wre, op_end, next_op_end, wrpe, next_wrpe, pge, next_pge;
  logic done_q, next_done, grant_q, next_grant, berr_q, next_berr;
  logic me_q, next_me, bk_q, next_bk, irq_q, next_irq;

  function automatic frp_pkg::frp_level_t decode(input logic [7:0] b, input logic [7:0] c);
    if (b == frp_pkg::LVL0_BYTE && c == frp_pkg::LVL0_COMP)
      decode = frp_pkg::FRP_LVL0;
    else if (b == frp_pkg::LVL2_BYTE && c == frp_pkg::LVL2_COMP)
      decode = frp_pkg::FRP_LVL2;
    else
      decode = frp_pkg::FRP_LVL1;
  endfunction

  function automatic logic at_top(input frp_pkg::frp_level_t l);
    at_top = (l == frp_pkg::FRP_LVL2);
  endfunction

  logic restricted, wr_prot, set_wrpe, set_pge, set_end, fault;
  always_comb begin
    next_lvl      = lvl;
    next_wp_mask  = wp_mask;
    next_loaded   = 1'b1;
    next_wre      = wre;
    next_done     = 1'b0;
    next_grant    = 1'b0;
    next_berr     = 1'b0;
    next_me       = 1'b0;
    next_bk       = 1'b0;
    set_wrpe      = 1'b0;
    set_pge       = 1'b0;
    set_end       = 1'b0;
    fault         = 1'b0;
    // debug and boot modes lose array access above level 0
    restricted    = (lvl != frp_pkg::FRP_LVL0) &&
                    (bus.debug_mode || bus.boot_ram || bus.boot_loader);
    grp           = bus.page[frp_pkg::PAGE_BITS-1:frp_pkg::GROUP_SH];
    // pages past the last mask bit are never protected
    wr_prot       = (grp < frp_pkg::WP_BITS) &&
                    !wp_mask[grp[$clog2(frp_pkg::WP_BITS)-1:0]];
    if (!loaded || option_reload_trigger) begin
      next_lvl     = decode(opt_level_byte, opt_level_comp);
      next_wp_mask = opt_protect_bits;
    end
    next_dis      = at_top(next_lvl);
    if (key_good)
      next_wre = 1'b1;
    else if (clear_wre)
      next_wre = 1'b0;
    if (bus.req) begin
      next_done = 1'b1;
      if (bus.is_reg) begin
        fault = (bus.size != frp_pkg::FRP_SIZE_WORD);
      end else if (!bus.is_write) begin
        fault = restricted && (bus.area == frp_pkg::FRP_AREA_MAIN ||
                               bus.area == frp_pkg::FRP_AREA_BACKUP);
      end else begin
        unique case (bus.op)
          frp_pkg::FRP_OP_PROG, frp_pkg::FRP_OP_PAGE_ERASE: begin
            if (bus.area == frp_pkg::FRP_AREA_SYSMEM) set_pge = 1'b1;
            else if (restricted) set_pge = 1'b1;
            else if (wr_prot) set_wrpe = 1'b1;
            else set_end = 1'b1;
          end
          frp_pkg::FRP_OP_MASS_ERASE: begin
            if (restricted) set_pge = 1'b1;
            else if (|(~wp_mask)) set_wrpe = 1'b1;
            else begin
              set_end = 1'b1;
              next_me = 1'b1;
              next_bk = 1'b1;
            end
          end
          frp_pkg::FRP_OP_OPT_PROG: begin
            if (!wre) set_wrpe = 1'b1;
            else if (bus.level_byte_sel && at_top(lvl)) set_wrpe = 1'b1;
            else begin
              set_end = 1'b1;
              if (bus.level_byte_sel && bus.wdata == frp_pkg::LVL0_BYTE) begin
                next_me = 1'b1;
                next_bk = (lvl == frp_pkg::FRP_LVL1);
              end
            end
          end
          frp_pkg::FRP_OP_OPT_ERASE: begin
            if (!wre || at_top(lvl)) set_wrpe = 1'b1;
            else set_end = 1'b1;
          end
          default: fault = 1'b1;
        endcase
      end
      next_berr  = fault;
      next_grant = !fault && !set_pge && !set_wrpe;
    end
    // set wins over a same-cycle clear
    next_op_end = set_end  | (op_end & ~clr_op_end);
    next_wrpe   = set_wrpe | (wrpe & ~clr_wrperr);
    next_pge    = set_pge  | (pge  & ~clr_prog_err);
    // irq registered from next flags, so it rises with them
    next_irq  = (next_op_end & end_of_operation_irq_enable) |
                ((next_wrpe | next_pge) & error_irq_enable);
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      lvl      <= frp_pkg::FRP_LVL1;
      wp_mask  <= '0;
      loaded   <= 1'b0;
      dis_q    <= 1'b0;
      wre      <= 1'b0;
      op_end   <= 1'b0;
      wrpe     <= 1'b0;
      pge      <= 1'b0;
      done_q   <= 1'b0;
      grant_q  <= 1'b0;
      berr_q   <= 1'b0;
      me_q     <= 1'b0;
      bk_q     <= 1'b0;
      irq_q    <= 1'b0;
    end else begin
      lvl      <= next_lvl;
      wp_mask  <= next_wp_mask;
      loaded   <= next_loaded;
      dis_q    <= next_dis;
      wre      <= next_wre;
      op_end   <= next_op_end;
      wrpe     <= next_wrpe;
      pge      <= next_pge;
      done_q   <= next_done;
      grant_q  <= next_grant;
      berr_q   <= next_berr;
      me_q     <= next_me;
      bk_q     <= next_bk;
      irq_q    <= next_irq;
    end
  end

  assign level                    = lvl;
  assign option_write_enable      = wre;
  assign end_of_operation_flag    = op_end;
  assign write_protect_error_flag = wrpe;
  assign program_error_flag       = pge;
  assign irq                      = irq_q;
  assign debug_disable            = dis_q;
  assign boot_disable             = dis_q;
  assign mass_erase_pulse         = me_q;
  assign backup_clear_pulse       = bk_q;
  assign bus.done                 = done_q;
  assign bus.granted              = grant_q;
  assign bus.bus_error            = berr_q;
endmodule

// ### verilog/frp_host.sv
`timescale 1ns/1ps
module frp_host (
  input  wire logic                          clk,        // system clock
  input  wire logic                          resetn,     // async reset
  frp_if.host                                bus,        // access side
  input  wire logic                          start,      // issue access pulse
  input  wire logic                          is_write,   // write or read
  input  wire frp_pkg::frp_area_t            area,       // target area
  input  wire frp_pkg::frp_size_t            size,       // transfer size
  input  wire logic                          is_reg,     // register access
  input  wire frp_pkg::frp_op_t              op,         // operation kind
  input  wire logic [frp_pkg::PAGE_BITS-1:0] page,       // target page
  input  wire logic                          level_byte_sel, // level byte targeted
  input  wire logic [7:0]                    wdata,      // option data
  input  wire logic                          debug_mode, // debugger attached
  input  wire logic                          boot_ram,   // boot from ram
  input  wire logic                          boot_loader,// boot loader
  output logic                               busy,       // access pending
  output logic                               ok,         // last access granted
  output logic                               err         // last access faulted
);
  logic req_q, next_req, busy_q, next_busy, ok_q, next_ok, err_q, next_err;
  logic is_write_q, is_reg_q, sel_q, next_is_write, next_is_reg, next_sel;
  frp_pkg::frp_area_t area_q, next_area;
  frp_pkg::frp_size_t size_q, next_size;
  frp_pkg::frp_op_t op_q, next_op;
  logic [frp_pkg::PAGE_BITS-1:0] page_q, next_page;
  logic [7:0] wd_q, next_wd;

  always_comb begin
    next_req = 1'b0;
    next_busy = busy_q;
    next_ok = ok_q;
    next_err = err_q;
    next_is_write = is_write_q;
    next_is_reg = is_reg_q;
    next_sel = sel_q;
    next_area = area_q;
    next_size = size_q;
    next_op = op_q;
    next_page = page_q;
    next_wd = wd_q;
    if (start && !busy_q) begin
      next_req = 1'b1;
      next_busy = 1'b1;
      next_is_write = is_write;
      next_is_reg = is_reg;
      next_sel = level_byte_sel;
      next_area = area;
      next_size = size;
      next_op = op;
      next_page = page;
      next_wd = wdata;
    end else if (busy_q && bus.done) begin
      next_busy = 1'b0;
      next_ok = bus.granted;
      next_err = bus.bus_error;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      req_q <= 1'b0;
      busy_q <= 1'b0;
      ok_q <= 1'b0;
      err_q <= 1'b0;
      is_write_q <= 1'b0;
      is_reg_q <= 1'b0;
      sel_q <= 1'b0;
      area_q <= frp_pkg::FRP_AREA_MAIN;
      size_q <= frp_pkg::FRP_SIZE_WORD;
      op_q <= frp_pkg::FRP_OP_NONE;
      page_q <= '0;
      wd_q <= '0;
    end else begin
      req_q <= next_req;
      busy_q <= next_busy;
      ok_q <= next_ok;
      err_q <= next_err;
      is_write_q <= next_is_write;
      is_reg_q <= next_is_reg;
      sel_q <= next_sel;
      area_q <= next_area;
      size_q <= next_size;
      op_q <= next_op;
      page_q <= next_page;
      wd_q <= next_wd;
    end
  end

  assign bus.req = req_q;
  assign bus.is_write = is_write_q;
  assign bus.is_reg = is_reg_q;
  assign bus.level_byte_sel = sel_q;
  assign bus.area = area_q;
  assign bus.size = size_q;
  assign bus.op = op_q;
  assign bus.page = page_q;
  assign bus.wdata = wd_q;
  assign bus.debug_mode = debug_mode;
  assign bus.boot_ram = boot_ram;
  assign bus.boot_loader = boot_loader;
  assign busy = busy_q;
  assign ok = ok_q;
  assign err = err_q;
endmodule

// ### sim/frp_chk.sv
`timescale 1ns/1ps
module frp_chk (
  input wire logic               clk,         // clock
  input wire logic               resetn,      // reset
  input wire logic               req,         // request
  input wire logic               is_write,    // write
  input wire logic               is_reg,      // register
  input wire frp_pkg::frp_area_t area,        // area
  input wire frp_pkg::frp_size_t size,        // size
  input wire frp_pkg::frp_op_t   op,          // operation
  input wire logic               debug_mode,  // debug
  input wire logic               boot_ram,    // ram boot
  input wire logic               boot_loader, // loader boot
  input wire logic               done,        // answer
  input wire logic               granted,     // performed
  input wire logic               bus_error    // fault
);
  logic rd;
  logic md;
  assign rd = req && !is_write && !is_reg;
  assign md = debug_mode || boot_ram || boot_loader;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  sequence s_fault;
    done && bus_error && !granted;
  endsequence
  sequence s_refused;
    done && !granted && !bus_error;
  endsequence
  answer_next_cycle_a: assert property (req |=> done) else $error("answer late");
  answer_has_cause_a: assert property (done |-> $past(req)) else $error("answer without request");
  done_single_a: assert property (done |=> !done) else $error("done held too long");
  answer_exclusive_a:
    assert property ((granted || bus_error) |-> done && !(granted && bus_error))
    else $error("bad answer code");
  reg_size_a:
    assert property (req && is_reg && size != frp_pkg::FRP_SIZE_WORD |=> s_fault)
    else $error("narrow register access not faulted");
  sysmem_read_a:
    assert property (rd && area == frp_pkg::FRP_AREA_SYSMEM && !md |=> done && granted)
    else $error("system memory read refused");
  sysmem_write_a:
    assert property (req && is_write && !is_reg && area == frp_pkg::FRP_AREA_SYSMEM &&
      op inside {frp_pkg::FRP_OP_PROG, frp_pkg::FRP_OP_PAGE_ERASE} |=> s_refused)
    else $error("system memory write not refused");
  option_read_a:
    assert property (rd && area == frp_pkg::FRP_AREA_OPTION && !md |=> granted)
    else $error("option read refused");
endmodule

// ### sim/tb_flash_read_write_protection.sv
`timescale 1ns/1ps
module tb_flash_read_write_protection;
  logic               clk, resetn, start, is_write, is_reg, level_byte_sel, busy, ok, err;
  logic               debug_mode, boot_ram, boot_loader, key_good, clear_wre;
  logic               option_reload_trigger, clr_op_end, clr_wrperr, clr_prog_err;
  logic               end_of_operation_irq_enable, error_irq_enable, option_write_enable;
  logic               end_of_operation_flag, write_protect_error_flag, program_error_flag;
  logic               irq, debug_disable, boot_disable, mass_erase_pulse, backup_clear_pulse;
  logic [1:0]         level;
  logic [5:0]         page;
  logic [7:0]         wdata, opt_level_byte, opt_level_comp, opt_protect_bits, st;
  frp_pkg::frp_area_t area;
  frp_pkg::frp_size_t size;
  frp_pkg::frp_op_t   op;
  int                 fails = 0, comparisons = 0, n_mass = 0, n_bkp = 0;
  logic [7:0]         dec_b [6] = '{8'hAA, 8'hCC, 8'hAA, 8'hFF, 8'h12, 8'hCC};
  logic [7:0]         dec_c [6] = '{8'h55, 8'h33, 8'h54, 8'hFF, 8'hED, 8'h32};
  logic [7:0]         dec_l [6] = '{8'h00, 8'h02, 8'h01, 8'h01, 8'h01, 8'h01};
  // level, irq, program error, protect error, op end, err, ok
  assign st = {level, irq, program_error_flag, write_protect_error_flag,
               end_of_operation_flag, err, ok};
  frp_if u_frp_if ();
  frp_device u_frp_device (.clk, .resetn, .bus(u_frp_if), .opt_level_byte, .opt_level_comp,
    .opt_protect_bits, .option_reload_trigger, .key_good, .clear_wre, .clr_op_end,
    .clr_wrperr, .clr_prog_err, .end_of_operation_irq_enable, .error_irq_enable, .level,
    .option_write_enable, .end_of_operation_flag, .write_protect_error_flag,
    .program_error_flag, .irq, .debug_disable, .boot_disable, .mass_erase_pulse,
    .backup_clear_pulse);
  frp_host u_frp_host (.clk, .resetn, .bus(u_frp_if), .start, .is_write, .area, .size,
    .is_reg, .op, .page, .level_byte_sel, .wdata, .debug_mode, .boot_ram, .boot_loader,
    .busy, .ok, .err);
  frp_chk u_frp_chk (.clk, .resetn, .req(u_frp_if.req), .is_write(u_frp_if.is_write),
    .is_reg(u_frp_if.is_reg), .area(u_frp_if.area), .size(u_frp_if.size),
    .op(u_frp_if.op), .debug_mode(u_frp_if.debug_mode), .boot_ram(u_frp_if.boot_ram),
    .boot_loader(u_frp_if.boot_loader), .done(u_frp_if.done),
    .granted(u_frp_if.granted), .bus_error(u_frp_if.bus_error));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    if (mass_erase_pulse === 1'b1) n_mass++;
    if (backup_clear_pulse === 1'b1) n_bkp++;
  end
  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic tick;
    @(posedge clk);
    #1;
  endtask
  task automatic reload(input logic [7:0] b, input logic [7:0] c, input logic [7:0] w);
    opt_level_byte = b;
    opt_level_comp = c;
    opt_protect_bits = w;
    option_reload_trigger = 1'b1;
    tick;
    option_reload_trigger = 1'b0;
    tick;
  endtask
  task automatic key_on;
    key_good = 1'b1;
    tick;
    key_good = 1'b0;
  endtask
  // a: 0 main 1 sysmem 2 option 3 backup; o: 0 none 1 prog 2 page 3 mass 4 opt 5 opt erase
  task automatic acc(input int w, input logic [1:0] a, input logic [2:0] o,
                     input logic [5:0] p, input logic [7:0] exp);
    is_write = w[0];
    area = frp_pkg::frp_area_t'(a);
    op = frp_pkg::frp_op_t'(o);
    page = p;
    start = 1'b1;
    {clr_op_end, clr_wrperr, clr_prog_err} = 3'h7;
    tick;
    start = 1'b0;
    {clr_op_end, clr_wrperr, clr_prog_err} = 3'h0;
    for (int i = 0; i < 6 && busy !== 1'b0; i++) tick;
    chk("status", st, exp);
  endtask
  initial begin
    repeat (3000) @(posedge clk);
    fails++;
    report_and_stop;
  end
  initial begin
    {resetn, start, is_write, is_reg, level_byte_sel, debug_mode, boot_ram, boot_loader} = 8'h00;
    {key_good, clear_wre, option_reload_trigger, clr_op_end, clr_wrperr, clr_prog_err} = 6'h00;
    end_of_operation_irq_enable = 1'b0;
    error_irq_enable = 1'b1;
    {opt_level_byte, opt_level_comp, opt_protect_bits, wdata} = {8'hAA, 8'h55, 8'hFF, 8'h00};
    area = frp_pkg::FRP_AREA_MAIN;
    op = frp_pkg::FRP_OP_NONE;
    page = 6'h00;
    size = frp_pkg::FRP_SIZE_WORD;
    repeat (4) @(posedge clk);
    chk("reset status", st, 8'h40);
    chk("reset outputs", {option_write_enable, debug_disable, boot_disable,
        mass_erase_pulse, backup_clear_pulse}, 8'h00);
    #1 resetn = 1'b1;
    tick;
    tick;
    chk("load level", level, 8'h00);
    for (int i = 0; i < 6; i++) begin
      reload(dec_b[i], dec_c[i], 8'hFF);
      chk("level", level, dec_l[i]);
    end
    opt_level_byte = 8'hAA;
    opt_level_comp = 8'h55;
    repeat (3) tick;
    chk("held level", level, 8'h01);
    reload(8'hAA, 8'h55, 8'hFF);
    $display("decode test done");
    debug_mode = 1'b1;
    acc(0, 2'h0, 3'h0, 6'h00, 8'h01);
    acc(1, 2'h0, 3'h1, 6'h00, 8'h05);
    acc(1, 2'h0, 3'h2, 6'h00, 8'h05);
    acc(1, 2'h2, 3'h5, 6'h00, 8'h28);
    debug_mode = 1'b0;
    key_on;
    chk("write enable", option_write_enable, 8'h01);
    clear_wre = 1'b1;
    tick;
    clear_wre = 1'b0;
    chk("write enable", option_write_enable, 8'h00);
    key_on;
    level_byte_sel = 1'b1;
    wdata = 8'hAA;
    acc(1, 2'h2, 3'h4, 6'h00, 8'h05);
    level_byte_sel = 1'b0;
    chk("pulses", {n_mass[3:0], n_bkp[3:0]}, 8'h10);
    acc(1, 2'h0, 3'h3, 6'h00, 8'h05);
    chk("pulses", {n_mass[3:0], n_bkp[3:0]}, 8'h21);
    $display("level zero test done");
    reload(8'hAA, 8'h55, 8'hFD);
    acc(1, 2'h0, 3'h1, 6'h03, 8'h28);
    acc(1, 2'h0, 3'h1, 6'h01, 8'h05);
    acc(1, 2'h0, 3'h2, 6'h02, 8'h28);
    acc(1, 2'h0, 3'h2, 6'h04, 8'h05);
    acc(1, 2'h0, 3'h3, 6'h00, 8'h28);
    chk("pulses", {n_mass[3:0], n_bkp[3:0]}, 8'h21);
    clr_wrperr = 1'b1;
    tick;
    clr_wrperr = 1'b0;
    chk("cleared", st, 8'h00);
    error_irq_enable = 1'b0;
    acc(1, 2'h0, 3'h1, 6'h02, 8'h08);
    error_irq_enable = 1'b1;
    key_on;
    acc(1, 2'h2, 3'h5, 6'h00, 8'h05);
    reload(8'hAA, 8'h55, 8'hFF);
    acc(1, 2'h0, 3'h1, 6'h03, 8'h05);
    $display("write protect test done");
    reload(8'h12, 8'hED, 8'hFF);
    acc(0, 2'h0, 3'h0, 6'h00, 8'h41);
    acc(1, 2'h0, 3'h1, 6'h00, 8'h45);
    acc(0, 2'h1, 3'h0, 6'h00, 8'h41);
    acc(1, 2'h1, 3'h1, 6'h00, 8'h70);
    for (int m = 0; m < 3; m++) begin
      {debug_mode, boot_ram, boot_loader} = 3'h4 >> m;
      acc(0, 2'h0, 3'h0, 6'h00, 8'h42);
      acc(0, 2'h3, 3'h0, 6'h00, 8'h42);
      acc(1, 2'h0, 3'h1, 6'h00, 8'h70);
      acc(1, 2'h0, 3'h2, 6'h00, 8'h70);
    end
    {debug_mode, boot_ram, boot_loader} = 3'h0;
    is_reg = 1'b1;
    for (int s = 0; s < 2; s++) begin
      size = frp_pkg::frp_size_t'(s);
      acc(0, 2'h0, 3'h0, 6'h00, 8'h42);
    end
    is_reg = 1'b0;
    size = frp_pkg::FRP_SIZE_WORD;
    key_on;
    level_byte_sel = 1'b1;
    acc(1, 2'h2, 3'h4, 6'h00, 8'h45);
    level_byte_sel = 1'b0;
    chk("pulses", {n_mass[3:0], n_bkp[3:0]}, 8'h32);
    $display("level one test done");
    reload(8'hCC, 8'h33, 8'hFF);
    chk("locks", {debug_disable, boot_disable}, 8'h03);
    key_on;
    level_byte_sel = 1'b1;
    acc(1, 2'h2, 3'h4, 6'h00, 8'hA8);
    level_byte_sel = 1'b0;
    acc(1, 2'h2, 3'h5, 6'h00, 8'hA8);
    acc(1, 2'h2, 3'h4, 6'h00, 8'h85);
    acc(0, 2'h2, 3'h0, 6'h00, 8'h81);
    error_irq_enable = 1'b0;
    end_of_operation_irq_enable = 1'b1;
    acc(1, 2'h0, 3'h1, 6'h00, 8'hA5);
    $display("level two test done");
    report_and_stop;
  end
endmodule
